// ### core/ctc_pkg.sv
// constants and types shared by the capture trigger control block
package ctc_pkg;

	localparam int unsigned CTC_AW_DEF     = 10;
	localparam int unsigned CTC_DW_DEF     = 32;

	localparam logic [7:0]  OFF_CMD        = 8'h00;
	localparam logic [7:0]  OFF_CFG        = 8'h04;
	localparam logic [7:0]  OFF_STATUS     = 8'h08;
	localparam logic [7:0]  OFF_WIN_IDX    = 8'h0C;
	localparam logic [7:0]  OFF_SAMP_CNT   = 8'h10;
	localparam logic [7:0]  OFF_TOTAL      = 8'h14;
	localparam logic [7:0]  OFF_VALID_WIN  = 8'h18;
	localparam logic [7:0]  OFF_LAST_LEN   = 8'h1C;
	localparam logic [7:0]  OFF_IRQ_STAT   = 8'h20;
	localparam logic [7:0]  OFF_IRQ_MASK   = 8'h24;
	localparam logic [7:0]  OFF_RD_ADDR    = 8'h28;
	localparam logic [7:0]  OFF_RD_DATA    = 8'h2C;

	localparam int unsigned CMD_ARM        = 0;
	localparam int unsigned CMD_IMM        = 1;
	localparam int unsigned CMD_STOP       = 2;
	localparam int unsigned CMD_DONE       = 3;

	localparam int unsigned ST_STATE_LSB   = 0;
	localparam int unsigned ST_SEQ_LSB     = 4;
	localparam int unsigned ST_FLAG_LSB    = 8;
	localparam int unsigned ST_STOPPED_BIT = 12;
	localparam int unsigned ST_IMM_BIT     = 13;

	localparam int unsigned EV_TRIG        = 0;
	localparam int unsigned EV_WIN         = 1;
	localparam int unsigned EV_FULL        = 2;
	localparam int unsigned EV_NUM         = 3;

	typedef struct packed {
		logic        adv;
		logic [3:0]  nwin_log2;
		logic [3:0]  win_log2;
		logic [15:0] trig_pos;
	} ctc_cfg_t;

	localparam ctc_cfg_t    CFG_RST        = 25'h00A0000;
	localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

	typedef struct packed {
		logic arm;
		logic imm;
		logic stop;
		logic done;
	} ctc_cmd_t;

	typedef enum logic [2:0] {
		CTC_IDLE = 3'b000,
		CTC_PRE  = 3'b001,
		CTC_WAIT = 3'b010,
		CTC_POST = 3'b011,
		CTC_FULL = 3'b100
	} ctc_state_t;

endpackage : ctc_pkg

// ### core/ctc_mem.sv
// sample store of the capture buffer, one write and one read port
`timescale 1ns/10ps
`default_nettype none
module ctc_mem #(
	parameter int unsigned AW = 10,
	parameter int unsigned DW = 32
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          we,
	input  wire logic [AW-1:0] waddr,
	input  wire logic [DW-1:0] wdata,
	input  wire logic [AW-1:0] raddr,
	output logic      [DW-1:0] rdata
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	logic [DW-1:0] rdata_r;

	always_ff @(posedge pclk)
	begin
		if (we)
		begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			rdata_r <= '0;
		end
		else
		begin
			rdata_r <= mem[raddr];
		end
	end

	assign rdata = rdata_r;
endmodule : ctc_mem
`default_nettype wire

// ### core/ctc_irq.sv
// sticky event status, mask and level interrupt
`timescale 1ns/10ps
`default_nettype none
module ctc_irq #(
	parameter int unsigned N = 3
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic [N-1:0] ev,
	input  wire logic [N-1:0] clr,
	input  wire logic         mask_we,
	input  wire logic [N-1:0] mask_wd,
	output logic      [N-1:0] stat,
	output logic      [N-1:0] mask,
	output logic              irq
);
	logic [N-1:0] stat_r;
	logic [N-1:0] stat_nxt;
	logic [N-1:0] mask_r;
	logic [N-1:0] mask_nxt;
	logic         irq_r;
	logic         irq_nxt;

	always_comb
	begin
		// set wins over a clear in the same cycle
		stat_nxt = (stat_r & ~clr) | ev;
		mask_nxt = mask_we ? mask_wd : mask_r;
		irq_nxt  = |(stat_nxt & mask_nxt);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			stat_r <= '0;
			mask_r <= N'(ctc_pkg::IRQ_MASK_RST);
			irq_r  <= 1'b0;
		end
		else
		begin
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			irq_r  <= irq_nxt;
		end
	end

	assign stat = stat_r;
	assign mask = mask_r;
	assign irq  = irq_r;
endmodule : ctc_irq
`default_nettype wire

// ### core/ctc_engine.sv
// capture trigger control engine with apb register file
//
// Overview of operation
// R1 - normal arm waits for configured trigger event
// R2 - immediate arm triggers without evaluating conditions
// R3 - arm: position 0 waits, else pre-capture
// R4 - pre-capture fills up to trigger position
// R5 - trigger at last sample goes straight full
// R6 - post-capture fills rest of window, then full
// R7 - full holds data until host upload done
// R8 - stop exposes all completely filled windows
// R9 - stop exposes partial window only if triggered
// R10 - host re-arms after each upload when automatic
// R11 - re-arm with both arms; stop ends capture
// R12 - report window, samples, total; zero when idle
// R13 - advanced mode reports four sequencer flags
// R14 - advanced waiting reports sequencer state
// R15 - host may command several cores together
// R16 - multiwindow position 0 re-arms next cycle
// R17 - trigger position spans zero to depth-1
// R18 - window depth is any power of two; the code handles 1 to 1024 only, and win_log2 above 10 gives a depth of 0
// R19 - stop then upload returns to cleared idle
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module ctc_engine #(
	parameter int unsigned AW = ctc_pkg::CTC_AW_DEF,
	parameter int unsigned DW = ctc_pkg::CTC_DW_DEF
) (
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          psel,
	input  wire logic          penable,
	input  wire logic          pwrite,
	input  wire logic [7:0]    paddr,
	input  wire logic [31:0]   pwdata,
	output logic      [31:0]   prdata,
	output logic               pready,
	output logic               pslverr,
	input  wire logic [DW-1:0] probe_data,
	input  wire logic          trig_hit,
	input  wire logic [3:0]    seq_state,
	input  wire logic [3:0]    seq_flags,
	output logic               irq
);
	localparam int unsigned CW = AW + 1;

	function automatic logic [CW-1:0] pow2(input logic [3:0] lg);
		pow2 = CW'(1) << lg;
	endfunction : pow2

	ctc_pkg::ctc_cfg_t   cfg_r;
	ctc_pkg::ctc_cfg_t   cfg_nxt;
	ctc_pkg::ctc_cmd_t   cmd;
	ctc_pkg::ctc_state_t state_r;
	ctc_pkg::ctc_state_t state_nxt;
	logic                pready_r;
	logic                pready_nxt;
	logic                pslverr_r;
	logic                pslverr_nxt;
	logic [31:0]         prdata_r;
	logic [31:0]         prdata_nxt;
	logic [31:0]         rd_mux;
	logic [31:0]         status_w;
	logic [AW-1:0]       rd_addr_r;
	logic [AW-1:0]       rd_addr_nxt;
	logic [CW-1:0]       win_idx_r;
	logic [CW-1:0]       win_idx_nxt;
	logic [CW-1:0]       samp_r;
	logic [CW-1:0]       samp_nxt;
	logic [CW-1:0]       total_r;
	logic [CW-1:0]       total_nxt;
	logic [CW-1:0]       valid_win_r;
	logic [CW-1:0]       valid_win_nxt;
	logic [CW-1:0]       last_len_r;
	logic [CW-1:0]       last_len_nxt;
	logic                imm_r;
	logic                imm_nxt;
	logic                seen_r;
	logic                seen_nxt;
	logic                stopped_r;
	logic                stopped_nxt;
	logic [CW-1:0]       win;
	logic [CW-1:0]       nwin;
	logic [CW-1:0]       pos;
	logic                trig_go;
	logic                last_smp;
	logic                store;
	logic                mem_we;
	logic [AW-1:0]       mem_waddr;
	logic [DW-1:0]       mem_rdata;
	logic [2:0]          ev;
	logic [2:0]          irq_stat;
	logic [2:0]          irq_mask;
	logic                wr;

	assign wr   = psel & penable & pready_r & pwrite;
	assign win  = pow2(cfg_r.win_log2); // see R18
	assign nwin = pow2(cfg_r.nwin_log2);
	assign pos  = CW'(cfg_r.trig_pos) & (win - 1'b1); // see R17
	// immediate arm ignores the condition logic
	assign trig_go  = imm_r | trig_hit; // see R1 see R2
	assign last_smp = (samp_r + 1'b1) == win;
	assign mem_waddr = AW'((win_idx_r << cfg_r.win_log2) | samp_r);

	always_comb
	begin
		cmd.arm  = wr && paddr == ctc_pkg::OFF_CMD && pwdata[ctc_pkg::CMD_ARM];
		cmd.imm  = wr && paddr == ctc_pkg::OFF_CMD && pwdata[ctc_pkg::CMD_IMM];
		cmd.stop = wr && paddr == ctc_pkg::OFF_CMD && pwdata[ctc_pkg::CMD_STOP];
		cmd.done = wr && paddr == ctc_pkg::OFF_CMD && pwdata[ctc_pkg::CMD_DONE];
	end

	always_comb
	begin
		state_nxt     = state_r;
		win_idx_nxt   = win_idx_r;
		samp_nxt      = samp_r;
		total_nxt     = total_r;
		valid_win_nxt = valid_win_r;
		last_len_nxt  = last_len_r;
		imm_nxt       = imm_r;
		seen_nxt      = seen_r;
		stopped_nxt   = stopped_r;
		store         = 1'b0;
		ev            = 3'h0;
		case (state_r)
			ctc_pkg::CTC_IDLE:
			begin
				if (cmd.arm || cmd.imm)
				begin
					imm_nxt   = cmd.imm; // see R2
					state_nxt = (pos == '0) ? ctc_pkg::CTC_WAIT
						: ctc_pkg::CTC_PRE; // see R3
				end
			end
			ctc_pkg::CTC_PRE:
			begin
				store = ~cmd.stop;
				if ((samp_r + 1'b1) == pos)
				begin
					state_nxt = ctc_pkg::CTC_WAIT; // see R4
				end
			end
			ctc_pkg::CTC_WAIT:
			begin
				if (trig_go && !cmd.stop)
				begin
					store     = 1'b1;
					seen_nxt  = 1'b1;
					ev[ctc_pkg::EV_TRIG] = 1'b1;
					state_nxt = ctc_pkg::CTC_POST; // see R5
				end
			end
			ctc_pkg::CTC_POST:
			begin
				store = ~cmd.stop; // see R6
			end
			ctc_pkg::CTC_FULL:
			begin
				if (cmd.done)
				begin
					state_nxt     = ctc_pkg::CTC_IDLE; // see R7 see R19
					win_idx_nxt   = '0; // see R12
					samp_nxt      = '0;
					total_nxt     = '0;
					valid_win_nxt = '0;
					last_len_nxt  = '0;
					seen_nxt      = 1'b0;
					stopped_nxt   = 1'b0;
					imm_nxt       = 1'b0;
				end
			end
			default:
			begin
				state_nxt = ctc_pkg::CTC_IDLE;
			end
		endcase
		if (store)
		begin
			samp_nxt  = samp_r + 1'b1;
			total_nxt = total_r + 1'b1;
		end
		if (store && last_smp)
		begin
			ev[ctc_pkg::EV_WIN] = 1'b1;
			if ((win_idx_r + 1'b1) == nwin)
			begin
				state_nxt     = ctc_pkg::CTC_FULL; // see R5 see R6
				valid_win_nxt = nwin;
				last_len_nxt  = win;
				ev[ctc_pkg::EV_FULL] = 1'b1;
			end
			else
			begin
				win_idx_nxt = win_idx_r + 1'b1;
				samp_nxt    = '0;
				seen_nxt    = 1'b0;
				state_nxt   = (pos == '0) ? ctc_pkg::CTC_WAIT
					: ctc_pkg::CTC_PRE; // see R16
			end
		end
		if (cmd.stop && state_r != ctc_pkg::CTC_IDLE
			&& state_r != ctc_pkg::CTC_FULL)
		begin
			state_nxt     = ctc_pkg::CTC_FULL; // see R8 see R11
			stopped_nxt   = 1'b1;
			valid_win_nxt = win_idx_r + CW'(seen_r); // see R9
			last_len_nxt  = seen_r ? samp_r
				: ((win_idx_r == '0) ? '0 : win);
			ev[ctc_pkg::EV_FULL] = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r     <= ctc_pkg::CTC_IDLE;
			win_idx_r   <= '0;
			samp_r      <= '0;
			total_r     <= '0;
			valid_win_r <= '0;
			last_len_r  <= '0;
			imm_r       <= 1'b0;
			seen_r      <= 1'b0;
			stopped_r   <= 1'b0;
		end
		else
		begin
			state_r     <= state_nxt;
			win_idx_r   <= win_idx_nxt;
			samp_r      <= samp_nxt;
			total_r     <= total_nxt;
			valid_win_r <= valid_win_nxt;
			last_len_r  <= last_len_nxt;
			imm_r       <= imm_nxt;
			seen_r      <= seen_nxt;
			stopped_r   <= stopped_nxt;
		end
	end

	always_comb
	begin
		status_w = 32'(state_r) << ctc_pkg::ST_STATE_LSB;
		if (cfg_r.adv)
		begin
			status_w = status_w
				| (32'(seq_flags) << ctc_pkg::ST_FLAG_LSB); // see R13
		end
		if (cfg_r.adv && state_r == ctc_pkg::CTC_WAIT)
		begin
			status_w = status_w
				| (32'(seq_state) << ctc_pkg::ST_SEQ_LSB); // see R14
		end
		status_w[ctc_pkg::ST_STOPPED_BIT] = stopped_r;
		status_w[ctc_pkg::ST_IMM_BIT]     = imm_r;
		case (paddr)
			ctc_pkg::OFF_CFG:       rd_mux = 32'(cfg_r);
			ctc_pkg::OFF_STATUS:    rd_mux = status_w;
			ctc_pkg::OFF_WIN_IDX:   rd_mux = 32'(win_idx_r); // see R12
			ctc_pkg::OFF_SAMP_CNT:  rd_mux = 32'(samp_r);
			ctc_pkg::OFF_TOTAL:     rd_mux = 32'(total_r);
			ctc_pkg::OFF_VALID_WIN: rd_mux = 32'(valid_win_r);
			ctc_pkg::OFF_LAST_LEN:  rd_mux = 32'(last_len_r);
			ctc_pkg::OFF_IRQ_STAT:  rd_mux = 32'(irq_stat);
			ctc_pkg::OFF_IRQ_MASK:  rd_mux = 32'(irq_mask);
			ctc_pkg::OFF_RD_ADDR:   rd_mux = 32'(rd_addr_r);
			ctc_pkg::OFF_RD_DATA:   rd_mux = 32'(mem_rdata);
			default:                rd_mux = 32'h0000_0000;
		endcase
		pready_nxt  = psel & penable & ~pready_r;
		pslverr_nxt = pready_nxt & ((paddr[1:0] != 2'h0)
			| (paddr > ctc_pkg::OFF_RD_DATA));
		prdata_nxt  = (pready_nxt & ~pwrite) ? rd_mux : prdata_r;
		cfg_nxt     = (wr && paddr == ctc_pkg::OFF_CFG)
			? ctc_pkg::ctc_cfg_t'(pwdata[24:0]) : cfg_r;
		rd_addr_nxt = (wr && paddr == ctc_pkg::OFF_RD_ADDR)
			? pwdata[AW-1:0] : rd_addr_r;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
			cfg_r     <= ctc_pkg::CFG_RST;
			rd_addr_r <= '0;
		end
		else
		begin
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r  <= prdata_nxt;
			cfg_r     <= cfg_nxt;
			rd_addr_r <= rd_addr_nxt;
		end
	end

	assign mem_we = store;

	ctc_mem #(.AW(AW), .DW(DW)) u_mem (
		.pclk    (pclk),
		.presetn (presetn),
		.we      (mem_we),
		.waddr   (mem_waddr),
		.wdata   (probe_data),
		.raddr   (rd_addr_r),
		.rdata   (mem_rdata)
	);

	ctc_irq #(.N(ctc_pkg::EV_NUM)) u_irq (
		.pclk    (pclk),
		.presetn (presetn),
		.ev      (ev),
		.clr     ((wr && paddr == ctc_pkg::OFF_IRQ_STAT) ? pwdata[2:0] : 3'h0),
		.mask_we (wr && paddr == ctc_pkg::OFF_IRQ_MASK),
		.mask_wd (pwdata[2:0]),
		.stat    (irq_stat),
		.mask    (irq_mask),
		.irq     (irq)
	);

	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	property p_idle_clear;
		state_r == ctc_pkg::CTC_IDLE |-> win_idx_r == '0 && samp_r == '0
			&& total_r == '0;
	endproperty
	a_idle_clear: assert property (p_idle_clear) // see R12
		else $error("counters not zero in idle");

	property p_arm_wait;
		state_r == ctc_pkg::CTC_IDLE && (cmd.arm || cmd.imm) && pos == '0
			|=> state_r == ctc_pkg::CTC_WAIT;
	endproperty
	a_arm_wait: assert property (p_arm_wait) // see R3
		else $error("arm at position zero did not wait");

	property p_arm_pre;
		state_r == ctc_pkg::CTC_IDLE && (cmd.arm || cmd.imm) && pos != '0
			|=> state_r == ctc_pkg::CTC_PRE;
	endproperty
	a_arm_pre: assert property (p_arm_pre) // see R3
		else $error("arm did not enter pre-capture");

	property p_imm_fires;
		state_r == ctc_pkg::CTC_WAIT && imm_r && !cmd.stop
			|=> total_r == $past(total_r) + 1'b1;
	endproperty
	a_imm_fires: assert property (p_imm_fires) // see R2
		else $error("immediate arm did not capture");

	property p_wait_hold;
		state_r == ctc_pkg::CTC_WAIT && !trig_go && !cmd.stop
			|=> state_r == ctc_pkg::CTC_WAIT && $stable(total_r);
	endproperty
	a_wait_hold: assert property (p_wait_hold) // see R1
		else $error("left waiting without trigger");

	property p_pre_done;
		state_r == ctc_pkg::CTC_PRE && !cmd.stop && (samp_r + 1'b1) == pos
			|=> state_r == ctc_pkg::CTC_WAIT && samp_r == $past(pos);
	endproperty
	a_pre_done: assert property (p_pre_done) // see R4
		else $error("pre-capture did not end at position");

	property p_post_full;
		state_r == ctc_pkg::CTC_POST && !cmd.stop && last_smp
			&& (win_idx_r + 1'b1) == nwin |=> state_r == ctc_pkg::CTC_FULL
			&& valid_win_r == $past(nwin);
	endproperty
	a_post_full: assert property (p_post_full) // see R6
		else $error("post-capture did not reach full");

	property p_last_pos;
		state_r == ctc_pkg::CTC_WAIT && trig_go && !cmd.stop
			&& pos == win - 1'b1 && (win_idx_r + 1'b1) == nwin
			|=> state_r == ctc_pkg::CTC_FULL;
	endproperty
	a_last_pos: assert property (p_last_pos) // see R5
		else $error("trigger at last sample not full");

	property p_full_hold;
		state_r == ctc_pkg::CTC_FULL && !cmd.done
			|=> state_r == ctc_pkg::CTC_FULL ##0 $stable(total_r);
	endproperty
	a_full_hold: assert property (p_full_hold) // see R7
		else $error("full state left before upload done");

	property p_stop;
		(state_r == ctc_pkg::CTC_PRE || state_r == ctc_pkg::CTC_WAIT
			|| state_r == ctc_pkg::CTC_POST) && cmd.stop
			|=> state_r == ctc_pkg::CTC_FULL && stopped_r
			&& valid_win_r == $past(win_idx_r) + CW'($past(seen_r));
	endproperty
	a_stop: assert property (p_stop) // see R8 see R9
		else $error("stop window count wrong");

	property p_rearm0;
		state_r == ctc_pkg::CTC_POST && !cmd.stop && last_smp
			&& (win_idx_r + 1'b1) != nwin && pos == '0
			|=> state_r == ctc_pkg::CTC_WAIT && samp_r == '0;
	endproperty
	a_rearm0: assert property (p_rearm0) // see R16
		else $error("no re-arm after window");
endmodule : ctc_engine
`default_nettype wire

// ### dv/ctc_host_model.sv
// host debug software model: apb master issuing register transfers
`timescale 1ns/10ps
`default_nettype none
module ctc_host_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic err;
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		err = 1'b0;
	end
	// setup, access, hold until pready seen high
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no cycle limit here: only the bench watchdog ends a wait
		do
		begin
			@(posedge pclk);
		end
		while (pready !== 1'b1);
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
	endtask : xfer
	// one command write; the same word may go to several cores
	task cmd(input int b);
		logic [31:0] r;
		xfer(1'b1, ctc_pkg::OFF_CMD, 32'h1 << b, r);
	endtask : cmd
endmodule : ctc_host_model
`default_nettype wire

// ### dv/capture_trigger_control_tb_top.sv
// self-checking testbench of the capture trigger control engine
`timescale 1ns/10ps
`default_nettype none
module capture_trigger_control_tb_top;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic        trig_hit, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, probe_data, fire_at, rv, base;
	logic [3:0]  seq_state, seq_flags;
	int          miscompares, cmp_count;

	ctc_engine uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .probe_data(probe_data), .trig_hit(trig_hit),
		.seq_state(seq_state), .seq_flags(seq_flags), .irq(irq));
	ctc_host_model host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// probe counts up; trigger pulses when probe equals fire_at
	always @(posedge pclk)
	begin
		probe_data <= probe_data + 32'h1;
		trig_hit <= (probe_data + 32'h1 == fire_at);
	end

	task complete_run;
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		cmp_count++;
		if (got !== exp)
		begin
			miscompares++;
			$display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : chk
	task rd(input logic [7:0] a);
		host.xfer(1'b0, a, 32'h0, rv);
	endtask : rd
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		host.xfer(1'b1, a, d, r);
	endtask : wr
	task poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
		int n;
		n = 0;
		do
		begin
			rd(a);
			n++;
		end
		while ((rv & m) !== v && n < 200);
		chk(rv & m, v, "poll");
	endtask : poll
	task mem(input logic [9:0] a, input logic [31:0] e);
		wr(ctc_pkg::OFF_RD_ADDR, {22'h0, a});
		rd(ctc_pkg::OFF_RD_DATA);
		chk(rv, e, "sample");
	endtask : mem
	function automatic logic [31:0] cfg(logic adv, logic [3:0] nw,
		logic [3:0] w, logic [15:0] p);
		return {7'h00, adv, nw, w, p};
	endfunction : cfg
	// upload done, then idle with all counters cleared
	task finish_up;
		wr(ctc_pkg::OFF_IRQ_STAT, 32'h7);
		host.cmd(ctc_pkg::CMD_DONE);
		rd(ctc_pkg::OFF_STATUS);
		chk(rv & 32'h7, 32'h0, "idle");
		rd(ctc_pkg::OFF_WIN_IDX);
		chk(rv, 32'h0, "win idx");
		rd(ctc_pkg::OFF_SAMP_CNT);
		chk(rv, 32'h0, "samp cnt");
		rd(ctc_pkg::OFF_TOTAL);
		chk(rv, 32'h0, "total");
	endtask : finish_up
	task reg_basics;
		rd(ctc_pkg::OFF_CFG);
		chk(rv, 32'h000A0000, "cfg reset");
		rd(ctc_pkg::OFF_IRQ_MASK);
		chk(rv, 32'h0, "mask reset");
		rd(8'h30);
		chk({rv[30:0], host.err}, 32'h1, "unmapped");
		rd(8'h06);
		chk({rv[30:0], host.err}, 32'h1, "unaligned");
		wr(ctc_pkg::OFF_IRQ_MASK, 32'h7);
		rd(ctc_pkg::OFF_IRQ_MASK);
		chk(rv, 32'h7, "mask");
	endtask : reg_basics
	task run_single(input logic [3:0] w, input logic [15:0] p);
		logic [31:0] d;
		d = 32'h1 << w;
		wr(ctc_pkg::OFF_CFG, cfg(1'b0, 4'h0, w, p));
		host.cmd(ctc_pkg::CMD_ARM);
		rd(ctc_pkg::OFF_STATUS);
		if (p >= 8)
			chk(rv & 32'h7, 32'h1, "pre");
		if (p == 0)
			chk(rv & 32'h7, 32'h2, "wait");
		poll(ctc_pkg::OFF_STATUS, 32'h7, 32'h2);
		fire_at = probe_data + 32'd6;
		poll(ctc_pkg::OFF_STATUS, 32'h7, 32'h4);
		mem(p[9:0], fire_at);
		mem(d[9:0] - 10'h1, fire_at + d - 32'h1 - p);
		rd(ctc_pkg::OFF_TOTAL);
		chk(rv, d, "total");
		rd(ctc_pkg::OFF_IRQ_STAT);
		chk(rv, 32'h7, "irq stat");
		chk({31'h0, irq}, 32'h1, "irq on");
		wr(ctc_pkg::OFF_IRQ_STAT, 32'h7);
		rd(ctc_pkg::OFF_IRQ_STAT);
		chk({rv[30:0], irq}, 32'h0, "irq clear");
		finish_up();
	endtask : run_single
	task multi_imm;
		wr(ctc_pkg::OFF_CFG, cfg(1'b0, 4'h1, 4'h2, 16'h0));
		host.cmd(ctc_pkg::CMD_IMM);
		poll(ctc_pkg::OFF_STATUS, 32'h2007, 32'h2004);
		rd(ctc_pkg::OFF_VALID_WIN);
		chk(rv, 32'h2, "windows");
		wr(ctc_pkg::OFF_RD_ADDR, 32'h0);
		rd(ctc_pkg::OFF_RD_DATA);
		base = rv;
		for (int i = 1; i < 8; i++)
			mem(i[9:0], base + i);
		finish_up();
	endtask : multi_imm
	task adv_stop;
		seq_state <= 4'h5;
		seq_flags <= 4'hA;
		wr(ctc_pkg::OFF_CFG, cfg(1'b1, 4'h2, 4'h2, 16'h0));
		host.cmd(ctc_pkg::CMD_ARM);
		poll(ctc_pkg::OFF_STATUS, 32'hFF7, 32'hA52);
		fire_at = probe_data + 32'd6;
		poll(ctc_pkg::OFF_WIN_IDX, 32'hFFFFFFFF, 32'h1);
		poll(ctc_pkg::OFF_STATUS, 32'hFF7, 32'hA52);
		host.cmd(ctc_pkg::CMD_STOP);
		rd(ctc_pkg::OFF_STATUS);
		chk(rv & 32'h1FF7, 32'h1A04, "stopped");
		rd(ctc_pkg::OFF_VALID_WIN);
		chk(rv, 32'h1, "full windows");
		rd(ctc_pkg::OFF_LAST_LEN);
		chk(rv, 32'h4, "last len");
		finish_up();
		rd(ctc_pkg::OFF_STATUS);
		chk(rv & 32'hFF0, 32'hA00, "adv idle");
	endtask : adv_stop
	task stop_case(input logic trig);
		wr(ctc_pkg::OFF_CFG, cfg(1'b0, 4'h0, 4'h4, 16'h0));
		host.cmd(ctc_pkg::CMD_ARM);
		poll(ctc_pkg::OFF_STATUS, 32'h7, 32'h2);
		if (trig)
			fire_at = probe_data + 32'd2;
		repeat (4) @(posedge pclk);
		host.cmd(ctc_pkg::CMD_STOP);
		rd(ctc_pkg::OFF_VALID_WIN);
		chk(rv, {31'h0, trig}, "partial");
		if (trig)
			mem(10'h0, fire_at);
		finish_up();
	endtask : stop_case

	initial
	begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		complete_run();
	end
	initial
	begin
		presetn = 1'b0;
		probe_data = 32'h0;
		trig_hit = 1'b0;
		fire_at = 32'hFFFFFFFF;
		seq_state = 4'h0;
		seq_flags = 4'h0;
		miscompares = 0;
		cmp_count = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		reg_basics();
		run_single(4'h4, 16'd10);
		run_single(4'h2, 16'd3);
		run_single(4'h0, 16'd0);
		multi_imm();
		adv_stop();
		stop_case(1'b0);
		stop_case(1'b1);
		complete_run();
	end
endmodule : capture_trigger_control_tb_top
`default_nettype wire
